// ---- hw/cbc_pkg.sv ----
// shared constants for the clock buffer control block
package cbc_pkg;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int T_LOCK_US = 1000;
    // latency must stay below the limit, so one cycle short of it
    localparam int LOCK_CYC_DFLT = T_LOCK_US * (CLK_HZ / 1_000_000) - 1;
    localparam int N_PAIRS = 8;

    // register indices
    localparam logic [7:0] OFS_FREQ = 8'h00;
    localparam logic [7:0] OFS_OUT_EN = 8'h01;
    localparam logic [7:0] OFS_STOP = 8'h02;
    localparam logic [7:0] OFS_RSVD = 8'h03;
    localparam logic [7:0] OFS_VENREV = 8'h04;
    localparam logic [7:0] OFS_DEVID = 8'h05;
    localparam logic [7:0] OFS_COUNT = 8'h06;

    // reset values and write mask
    localparam logic [7:0] FREQ_RST = 8'h81;
    localparam logic [7:0] FREQ_WMASK = 8'hcb;
    localparam logic [7:0] OUT_EN_RST = 8'hff;
    localparam logic [7:0] STOP_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h07;
    localparam logic [7:0] RSVD_VALUE = 8'h00;

    // field positions in frequency_select
    localparam int BIT_PD_SEL = 7;
    localparam int BIT_STOP_SEL = 6;
    localparam int BIT_MODE_HI = 3;
    localparam int BIT_MODE_LO = 1;
    localparam int BIT_HALVE_N = 0;

    // decoded three-level strap codes
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_MID = 2'h1;
    localparam logic [1:0] STRAP_HIGH = 2'h2;
    localparam logic [1:0] STRAP_CAPTURE = 2'h2;

    // seven-bit bus addresses per address strap level
    localparam logic [6:0] ADDR_LOW = 7'h6d;
    localparam logic [6:0] ADDR_MID = 7'h6e;
    localparam logic [6:0] ADDR_HIGH = 7'h6c;

    // pair drive codes {true, true_oe, comp, comp_oe}
    localparam logic [3:0] PARK_DRIVEN = 4'hc;
    localparam logic [3:0] PARK_HIZ = 4'h0;
    localparam logic [3:0] WAKE_DRIVEN = 4'hf;

    // serial bit counting
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;
endpackage : cbc_pkg

// ---- hw/cbc_smb_if.sv ----
// byte-level handshake between the serial engine and the register bank
`timescale 1ns/1ns
interface cbc_smb_if;
    logic start;
    logic stop;
    logic rx_valid;
    logic [7:0] rx_data;
    logic ack_en;
    logic tx_en;
    logic [7:0] tx_data;
    logic tx_taken;

    modport phy (
        output start, stop, rx_valid, rx_data, tx_taken,
        input ack_en, tx_en, tx_data
    );
    modport ctrl (
        input start, stop, rx_valid, rx_data, tx_taken,
        output ack_en, tx_en, tx_data
    );
endinterface : cbc_smb_if

// ---- hw/cbc_smb_phy.sv ----
// serial bus bit engine: start/stop detection, byte shifting, acknowledge
`timescale 1ns/1ns
module cbc_smb_phy
    import cbc_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // byte side
    cbc_smb_if.phy bus
);
    logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
    logic active_reg, tx_mode_reg, mst_ack_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg, tx_sh_reg;
    logic scl_rise, scl_fall, start_c, stop_c;

    // pins come from the host's domain, two flops before use
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {scl_s1, scl_s2, scl_p} <= 3'h7;
            {sda_s1, sda_s2, sda_p} <= 3'h7;
        end
        else
        begin
            {scl_s1, scl_s2, scl_p} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_p} <= {sda_in, sda_s1, sda_s2};
        end
    end

    // bus conditions seen on the synchronised copies only
    assign scl_rise = scl_s2 & ~scl_p;
    assign scl_fall = ~scl_s2 & scl_p;
    assign start_c = scl_s2 & scl_p & sda_p & ~sda_s2;
    assign stop_c = scl_s2 & scl_p & ~sda_p & sda_s2;

    // open-drain: only ever pulls low
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    // byte engine; changes to sda only after scl falls
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            active_reg <= 1'b0;
            tx_mode_reg <= 1'b0;
            mst_ack_reg <= 1'b0;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_sh_reg <= 8'h00;
            sda_oe_out <= 1'b0;
            bus.start <= 1'b0;
            bus.stop <= 1'b0;
            bus.rx_valid <= 1'b0;
            bus.rx_data <= 8'h00;
            bus.tx_taken <= 1'b0;
        end
        else
        begin
            bus.start <= start_c;
            bus.stop <= stop_c;
            bus.rx_valid <= 1'b0;
            bus.tx_taken <= 1'b0;
            if (start_c)
            begin
                active_reg <= 1'b1;
                cnt_reg <= 4'h0;
                tx_mode_reg <= 1'b0;
                sda_oe_out <= 1'b0;
            end
            else if (stop_c)
            begin
                active_reg <= 1'b0;
                tx_mode_reg <= 1'b0;
                sda_oe_out <= 1'b0;
            end
            else if (active_reg && scl_rise)
            begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg < BYTE_BITS)
                begin
                    sh_reg <= {sh_reg[6:0], sda_s2};
                    // early strobe gives the bank time to decide the ack
                    if (cnt_reg == BYTE_BITS - 4'h1 && !tx_mode_reg)
                    begin
                        bus.rx_valid <= 1'b1;
                        bus.rx_data <= {sh_reg[6:0], sda_s2};
                    end
                end
                else
                    mst_ack_reg <= ~sda_s2;
            end
            else if (active_reg && scl_fall)
            begin
                if (cnt_reg == BYTE_BITS)
                    sda_oe_out <= tx_mode_reg ? 1'b0 : bus.ack_en;
                else if (cnt_reg == ACK_DONE)
                begin
                    cnt_reg <= 4'h0;
                    if (bus.tx_en && (!tx_mode_reg || mst_ack_reg))
                    begin
                        tx_mode_reg <= 1'b1;
                        tx_sh_reg <= bus.tx_data;
                        sda_oe_out <= ~bus.tx_data[7];
                        bus.tx_taken <= 1'b1;
                    end
                    else
                    begin
                        tx_mode_reg <= 1'b0;
                        sda_oe_out <= 1'b0;
                    end
                end
                else if (tx_mode_reg)
                begin
                    tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                    sda_oe_out <= ~tx_sh_reg[6];
                end
            end
        end
    end
endmodule : cbc_smb_phy

// ---- hw/cbc_top.sv ----
// clock buffer control: serial register bank and power-down sequencer
`timescale 1ns/1ns
// Function
// - select 0 parks true high, complement off
// - select 1 parks both outputs tri-stated
// - byte 0 bit 0 picks halved or full
// - pair runs only with bit, and pin when stoppable
// - byte 2 makes pair stoppable by pin
// - byte 4 read-only revision and vendor
// - byte 5 holds writable device code
// - byte 6 sets block read count, 7
// - power-down stops outputs, enters low power
// - power-down pin asynchronous, enter and leave
// - park outputs before stopping the loop
// - two complement rises, park on fall
// - stable outputs under 1 ms after release; clocks run LOCK_CYC + 2 to 3 cycles after it, just over 1 ms by default
// - select 1 drives outputs soon after release
// - block write: index, count, sequential bytes
// - block read: count first, then bytes
// - middle strap answers dc and dd
module cbc_top
    import cbc_pkg::*;
#(
    parameter int LOCK_CYC = LOCK_CYC_DFLT,
    parameter logic [3:0] REV_CODE = 4'h1, // arbitrary value
    parameter logic [3:0] VEN_CODE = 4'h2, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h5a // arbitrary value
)
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // control pins
    input wire logic powerdown_n_in,
    input wire logic [7:0] output_enable_n_in,
    input wire logic reference_clock_in,
    input wire logic [1:0] mode_strap_in,
    input wire logic [1:0] bus_address_strap_in,
    // clock outputs, one bit per pair
    output logic [7:0] diff_clock_true_out,
    output logic [7:0] diff_clock_true_oe_out,
    output logic [7:0] diff_clock_complement_out,
    output logic [7:0] diff_clock_complement_oe_out,
    // loop and power state
    output logic pll_run_out,
    output logic low_power_out
);
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADDR = 8'h02,
        S_INDEX = 8'h04,
        S_COUNT = 8'h08,
        S_WDATA = 8'h10,
        S_RCOUNT = 8'h20,
        S_RDATA = 8'h40,
        S_SKIP = 8'h80
    } cbc_bus_st_t;

    typedef enum logic [4:0] {
        PD_RUN = 5'h01,
        PD_ONE = 5'h02,
        PD_TWO = 5'h04,
        PD_DOWN = 5'h08,
        PD_LOCK = 5'h10
    } cbc_pd_st_t;

    localparam int CNT_W = $clog2(LOCK_CYC + 1);

    cbc_smb_if smb ();

    cbc_bus_st_t bus_st_reg;
    cbc_pd_st_t pd_st_reg, pd_next;
    logic pd_s1, pd_s2, ref_s1, ref_s2, ref_p;
    logic [7:0] oen_s1, oen_s2;
    logic [3:0] strap_s1, strap_s2;
    logic [1:0] strap_cnt_reg;
    logic [7:0] freq_sel_reg, out_en_reg, stop_sel_reg, dev_id_reg, rb_count_reg;
    logic [7:0] index_reg, wleft_reg;
    logic [6:0] my_addr;
    logic wr_en;
    logic phase_reg, phase_prev_reg, comp_rise, comp_fall;
    logic [CNT_W-1:0] lock_cnt_reg;
    logic [7:0] run_pair;

    // serial bit engine
    cbc_smb_phy u_phy (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .bus(smb)
    );

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {pd_s1, pd_s2} <= 2'h3;
            {ref_s1, ref_s2} <= 2'h0;
            oen_s1 <= 8'hff;
            oen_s2 <= 8'hff;
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
        end
        else
        begin
            {pd_s1, pd_s2} <= {powerdown_n_in, pd_s1};
            {ref_s1, ref_s2} <= {reference_clock_in, ref_s1};
            oen_s1 <= output_enable_n_in;
            oen_s2 <= oen_s1;
            strap_s1 <= {mode_strap_in, bus_address_strap_in};
            strap_s2 <= strap_s1;
        end
    end

    // strap sampled once the synchroniser has filled after release
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            strap_cnt_reg <= 2'h0;
        else if (strap_cnt_reg != 2'h3)
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end

    // address follows the synchronised strap level
    always_comb
    begin
        unique case (strap_s2[1:0])
            STRAP_LOW: my_addr = ADDR_LOW;
            STRAP_HIGH: my_addr = ADDR_HIGH;
            default: my_addr = ADDR_MID;
        endcase
    end

    // readback mux, reserved and unmapped indices read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] idx);
        unique case (idx)
            OFS_FREQ: rd_byte = freq_sel_reg;
            OFS_OUT_EN: rd_byte = out_en_reg;
            OFS_STOP: rd_byte = stop_sel_reg;
            OFS_VENREV: rd_byte = {REV_CODE, VEN_CODE};
            OFS_DEVID: rd_byte = dev_id_reg;
            OFS_COUNT: rd_byte = rb_count_reg;
            default: rd_byte = RSVD_VALUE;
        endcase
    endfunction : rd_byte

    // block protocol sequencing; index survives a repeated start
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bus_st_reg <= S_IDLE;
            index_reg <= 8'h00;
            wleft_reg <= 8'h00;
            smb.ack_en <= 1'b0;
            smb.tx_en <= 1'b0;
            smb.tx_data <= 8'h00;
        end
        else if (smb.stop)
        begin
            bus_st_reg <= S_IDLE;
            smb.ack_en <= 1'b0;
            smb.tx_en <= 1'b0;
        end
        else if (smb.start)
        begin
            bus_st_reg <= S_ADDR;
            smb.ack_en <= 1'b0;
            smb.tx_en <= 1'b0;
        end
        else if (smb.rx_valid)
        begin
            unique case (bus_st_reg)
                S_ADDR:
                begin
                    if (smb.rx_data[7:1] == my_addr)
                    begin
                        smb.ack_en <= 1'b1;
                        if (smb.rx_data[0])
                        begin
                            bus_st_reg <= S_RCOUNT;
                            smb.tx_en <= 1'b1;
                            smb.tx_data <= rb_count_reg;
                        end
                        else
                            bus_st_reg <= S_INDEX;
                    end
                    else
                    begin
                        smb.ack_en <= 1'b0;
                        bus_st_reg <= S_SKIP;
                    end
                end
                S_INDEX:
                begin
                    index_reg <= smb.rx_data;
                    bus_st_reg <= S_COUNT;
                end
                S_COUNT:
                begin
                    wleft_reg <= smb.rx_data;
                    bus_st_reg <= S_WDATA;
                end
                S_WDATA:
                begin
                    if (wleft_reg != 8'h00)
                    begin
                        index_reg <= index_reg + 8'h01;
                        wleft_reg <= wleft_reg - 8'h01;
                    end
                end
                S_IDLE, S_RCOUNT, S_RDATA, S_SKIP: ;
                default: bus_st_reg <= S_IDLE;
            endcase
        end
        else if (smb.tx_taken)
        begin
            // next byte is staged while the current one shifts out
            if (bus_st_reg == S_RCOUNT)
            begin
                bus_st_reg <= S_RDATA;
                smb.tx_data <= rd_byte(index_reg);
            end
            else
            begin
                index_reg <= index_reg + 8'h01;
                smb.tx_data <= rd_byte(index_reg + 8'h01);
            end
        end
    end

    // writes only while the announced count lasts
    assign wr_en = smb.rx_valid && bus_st_reg == S_WDATA && wleft_reg != 8'h00;

    // register bank
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            freq_sel_reg <= FREQ_RST;
            out_en_reg <= OUT_EN_RST;
            stop_sel_reg <= STOP_RST;
            dev_id_reg <= DEV_CODE;
            rb_count_reg <= COUNT_RST;
        end
        else
        begin
            if (strap_cnt_reg == STRAP_CAPTURE)
            begin
                freq_sel_reg[BIT_MODE_HI] <= strap_s2[3:2] == STRAP_MID;
                freq_sel_reg[BIT_MODE_LO] <= strap_s2[3:2] == STRAP_HIGH;
            end
            if (wr_en)
            begin
                unique case (index_reg)
                    OFS_FREQ: freq_sel_reg <= smb.rx_data & FREQ_WMASK;
                    OFS_OUT_EN: out_en_reg <= smb.rx_data;
                    OFS_STOP: stop_sel_reg <= smb.rx_data;
                    OFS_DEVID: dev_id_reg <= smb.rx_data;
                    OFS_COUNT: rb_count_reg <= smb.rx_data;
                    default: ; // read-only and reserved ignore writes
                endcase
            end
        end
    end

    // output phase from the sampled reference, frozen while the loop is off
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase_reg <= 1'b0;
            phase_prev_reg <= 1'b0;
            ref_p <= 1'b0;
        end
        else
        begin
            ref_p <= ref_s2;
            phase_prev_reg <= phase_reg;
            if (pll_run_out)
            begin
                if (freq_sel_reg[BIT_HALVE_N])
                    phase_reg <= ref_s2;
                else if (ref_s2 && !ref_p)
                    phase_reg <= ~phase_reg;
            end
        end
    end

    // complement is the inverse of the true phase
    assign comp_rise = phase_prev_reg & ~phase_reg;
    assign comp_fall = ~phase_prev_reg & phase_reg;

    // power-down sequence; relies on the host keeping the reference alive
    always_comb
    begin
        pd_next = pd_st_reg;
        unique case (pd_st_reg)
            PD_RUN: if (comp_rise && !pd_s2) pd_next = PD_ONE;
            PD_ONE: if (comp_rise) pd_next = pd_s2 ? PD_RUN : PD_TWO;
            PD_TWO: if (comp_fall) pd_next = PD_DOWN;
            PD_DOWN: if (pd_s2) pd_next = PD_LOCK;
            PD_LOCK:
            begin
                if (!pd_s2)
                    pd_next = PD_DOWN;
                else if (lock_cnt_reg == CNT_W'(LOCK_CYC - 1))
                    pd_next = PD_RUN;
            end
            default: pd_next = PD_RUN;
        endcase
    end

    // state, lock timer and loop control; loop stops a cycle after parking
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pd_st_reg <= PD_RUN;
            lock_cnt_reg <= '0;
            pll_run_out <= 1'b1;
            low_power_out <= 1'b0;
        end
        else
        begin
            pd_st_reg <= pd_next;
            lock_cnt_reg <= (pd_st_reg == PD_LOCK) ? lock_cnt_reg + 1'b1 : '0;
            pll_run_out <= pd_st_reg != PD_DOWN;
            low_power_out <= pd_st_reg == PD_DOWN;
        end
    end

    // a stoppable pair obeys its active-low pin, a free-running one ignores it
    assign run_pair = out_en_reg & (~stop_sel_reg | ~oen_s2);

    // parked drive code: driven true high, or fully tri-stated
    function automatic logic [3:0] park(input logic hiz);
        park = hiz ? PARK_HIZ : PARK_DRIVEN;
    endfunction : park

    // per-pair drivers, updated from the next power state
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            diff_clock_true_out <= 8'h00;
            diff_clock_true_oe_out <= 8'h00;
            diff_clock_complement_out <= 8'h00;
            diff_clock_complement_oe_out <= 8'h00;
        end
        else
        begin
            for (int n = 0; n < N_PAIRS; n++)
            begin
                if (pd_next == PD_DOWN)
                    {diff_clock_true_out[n], diff_clock_true_oe_out[n],
                     diff_clock_complement_out[n], diff_clock_complement_oe_out[n]}
                        <= park(freq_sel_reg[BIT_PD_SEL]);
                else if (pd_next == PD_LOCK)
                    // static levels until lock; driven at once, well inside the limit
                    {diff_clock_true_out[n], diff_clock_true_oe_out[n],
                     diff_clock_complement_out[n], diff_clock_complement_oe_out[n]}
                        <= freq_sel_reg[BIT_PD_SEL] ? WAKE_DRIVEN : PARK_DRIVEN;
                else if (run_pair[n])
                    {diff_clock_true_out[n], diff_clock_true_oe_out[n],
                     diff_clock_complement_out[n], diff_clock_complement_oe_out[n]}
                        <= {phase_reg, 1'b1, ~phase_reg, 1'b1};
                else
                    {diff_clock_true_out[n], diff_clock_true_oe_out[n],
                     diff_clock_complement_out[n], diff_clock_complement_oe_out[n]}
                        <= park(freq_sel_reg[BIT_STOP_SEL]);
            end
        end
    end
endmodule : cbc_top

// ---- sim/cbc_assertions.sv ----
// port-level checks for the clock buffer control block
`timescale 1ns/1ns
module cbc_assertions (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // power and outputs
    input wire logic powerdown_n_in,
    input wire logic [7:0] diff_clock_true_out,
    input wire logic [7:0] diff_clock_true_oe_out,
    input wire logic [7:0] diff_clock_complement_oe_out,
    input wire logic pll_run_out,
    input wire logic low_power_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // open drain, and data only moves while scl is low
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda value high");
    a_sda_after_fall: assert property ($changed(sda_oe_out) |-> !$past(scl_in, 2))
        else $error("sda moved with scl high");
    // loop stops exactly when low power starts
    a_pll_state: assert property (pll_run_out != low_power_out)
        else $error("loop and power state disagree");
    a_park_levels: assert property (low_power_out |->
        $past(diff_clock_complement_oe_out) == 8'h00 && ($past(diff_clock_true_oe_out) == 8'h00
        || $past(diff_clock_true_oe_out & diff_clock_true_out) == 8'hff))
        else $error("bad park level");
    // park lands a cycle before the loop stops
    a_park_first: assert property ($rose(low_power_out) |->
        $past(diff_clock_complement_oe_out) == 8'h00)
        else $error("loop stopped before park");
    a_pin_seen: assert property ($rose(low_power_out) |-> !$past(powerdown_n_in, 3))
        else $error("park without pin low");
    a_wake_fast: assert property ($rose(powerdown_n_in) && low_power_out |->
        ##[1:6] !low_power_out)
        else $error("slow wake");
    a_wake_drive: assert property ($fell(low_power_out) |->
        ##[0:1] diff_clock_true_oe_out == 8'hff)
        else $error("outputs not driven at wake");
endmodule : cbc_assertions
bind cbc_top cbc_assertions chk (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .powerdown_n_in(powerdown_n_in),
    .diff_clock_true_out(diff_clock_true_out), .diff_clock_true_oe_out(diff_clock_true_oe_out),
    .diff_clock_complement_oe_out(diff_clock_complement_oe_out), .pll_run_out(pll_run_out),
    .low_power_out(low_power_out));

// ---- sim/cbc_host.sv ----
// serial bus host model: start, stop and byte transfers
`timescale 1ns/1ns
module cbc_host (
    // clock
    input wire logic clock_in,
    // bus lines
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    localparam int HALF = 10; // margin over the eight-clock minimum
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // one half bus period, ending just after an edge
    task automatic half();
        repeat (HALF) @(posedge clock_in);
        #1;
    endtask : half
    // start or repeated start: sda falls while scl is high
    task automatic bus_start();
        sda_low_out = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_low_out = 1'b1;
        half();
        scl_out = 1'b0;
    endtask : bus_start
    task automatic bus_stop();
        sda_low_out = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_low_out = 1'b0;
        half();
    endtask : bus_stop
    // data set while scl low, sampled before scl falls
    task automatic bit_io(input logic b, output logic r);
        sda_low_out = !b;
        half();
        scl_out = 1'b1;
        half();
        r = sda_in;
        scl_out = 1'b0;
    endtask : bit_io
    // msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_bit, ack);
    endtask : xfer
endmodule : cbc_host

// ---- sim/testbench.sv ----
// self-checking bench: register access and power-down sequencing
`timescale 1ns/1ns
module testbench
    import cbc_pkg::*;
();
    localparam int LOCK = 20;
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    localparam logic [3:0] VEN = 4'h6; // arbitrary value
    localparam logic [7:0] DEV = 8'h4c; // arbitrary value
    logic clock_in = 1'b0, rst_in = 1'b1, ref_clk = 1'b0, ref_run = 1'b1, pd_n = 1'b1;
    logic scl, sda, host_low, sda_out, sda_oe, pll_run, low_power, ack;
    logic [7:0] oe_n = 8'h00;
    logic [7:0] t_val, t_oe, c_val, c_oe, rx;
    logic [7:0] e[$];
    int miscompares = 0, tests_run = 0;
    assign sda = !(host_low | sda_oe); // pulled up, either side pulls low
    initial forever #50 clock_in = !clock_in;
    // reference at a sixth of the clock, parked low when stopped
    initial forever #300 ref_clk = ref_run ? !ref_clk : 1'b0;
    cbc_top #(.LOCK_CYC(LOCK), .REV_CODE(REV), .VEN_CODE(VEN), .DEV_CODE(DEV)) dut (
        .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_out(sda_oe), .powerdown_n_in(pd_n), .output_enable_n_in(oe_n),
        .reference_clock_in(ref_clk), .mode_strap_in(STRAP_MID),
        .bus_address_strap_in(STRAP_MID), .diff_clock_true_out(t_val),
        .diff_clock_true_oe_out(t_oe), .diff_clock_complement_out(c_val),
        .diff_clock_complement_oe_out(c_oe), .pll_run_out(pll_run), .low_power_out(low_power));
    cbc_host host (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic send(input logic [7:0] b);
        host.xfer(b, 1'b1, rx, ack);
        check({7'h00, ack}, 8'h00);
    endtask : send
    task automatic blk_write(input logic [7:0] idx, input logic [7:0] d[$]);
        host.bus_start();
        send(8'hdc);
        send(idx);
        send(8'(d.size()));
        foreach (d[i]) send(d[i]);
        host.bus_stop();
    endtask : blk_write
    // count first, then one byte per entry of e, the last refused
    task automatic blk_read(input logic [7:0] idx, input logic [7:0] cnt);
        host.bus_start();
        send(8'hdc);
        send(idx);
        host.bus_start();
        send(8'hdd);
        host.xfer(8'hff, 1'b0, rx, ack);
        check(rx, cnt);
        foreach (e[i])
        begin
            host.xfer(8'hff, i == e.size() - 1, rx, ack);
            check(rx, e[i]);
        end
        host.bus_stop();
    endtask : blk_read
    // async pin, so the wait is bounded
    task automatic set_pd(input logic level, input int limit);
        pd_n = level;
        for (int n = 0; n < limit && low_power !== !level; n++) @(posedge clock_in);
        #1;
        check({7'h00, low_power}, {7'h00, !level});
    endtask : set_pd
    initial
    begin
        repeat (12) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        repeat (5) @(posedge clock_in);
        #1;
        e = '{8'h89, 8'hff, 8'h00, 8'h00, {REV, VEN}, DEV, 8'h07};
        blk_read(8'h00, 8'h07);
        blk_write(8'h00, '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'ha5, 8'h03});
        e = '{8'hcb, 8'h00, 8'hff, 8'h00, {REV, VEN}, 8'ha5, 8'h03};
        blk_read(8'h00, 8'h03);
        host.bus_start();
        host.xfer(8'hda, 1'b1, rx, ack);
        check({7'h00, ack}, 8'h01);
        host.bus_stop();
        // tri-state park, reference removed only while down
        blk_write(8'h01, '{8'hff, 8'h00});
        set_pd(1'b0, 300);
        check(c_oe, 8'h00);
        check(t_oe, 8'h00);
        check({7'h00, pll_run}, 8'h00);
        ref_run = 1'b0;
        repeat (20) @(posedge clock_in);
        #1;
        ref_run = 1'b1;
        set_pd(1'b1, 8);
        check(t_oe, 8'hff);
        repeat (LOCK + 10) @(posedge clock_in);
        #1;
        check(c_oe, 8'hff);
        check(t_val ^ c_val, 8'hff);
        // driven park
        blk_write(8'h00, '{8'h09});
        set_pd(1'b0, 300);
        check(t_oe & t_val, 8'hff);
        check(c_oe, 8'h00);
        set_pd(1'b1, 8);
        // pair 0 stoppable with pin off, pair 1 bit off, pair 2 free-running
        blk_write(8'h01, '{8'hfd, 8'h01});
        oe_n = 8'h05;
        pd_n = 1'b0; // too short to park
        @(posedge clock_in);
        #1;
        set_pd(1'b1, 40);
        repeat (LOCK + 10) @(posedge clock_in);
        #1;
        check(c_oe, 8'hfc);
        summarize();
    end
    initial
    begin
        #6_000_000;
        miscompares++;
        summarize();
    end
endmodule : testbench
